// [logic/csc_top.sv]
// capacitive sense control: pin mux, mode decode, timers, Avalon-MM slave
`timescale 1ns/10ps
`default_nettype none
module csc_top
  import csc_pkg::*;
#(
  parameter int unsigned NUM_CH = CSC_NUM_CH,
  parameter int unsigned TA_W   = 8,
  parameter int unsigned TB_W   = 16
) (
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic [CSC_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [CSC_DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [CSC_DATA_W-1:0] avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  osc_comp_in,
  input  wire logic                  ext_clk_pin_in,
  input  wire logic                  gate_pin_in,
  output csc_analog_t                analog_ctl
);

  generate
    if (NUM_CH != CSC_NUM_CH) begin : g_bad_ch
      $error("csc_top serves exactly four sense pins");
    end
    if (TA_W < 2 || TA_W > 8) begin : g_bad_ta
      $error("csc_top timer_a width must be 2 to 8");
    end
    if (TB_W < 9 || TB_W > 16) begin : g_bad_tb
      $error("csc_top timer_b width must be 9 to 16");
    end
    if (CSC_INSTR_DIV < 2 || CSC_INSTR_DIV > 4) begin : g_bad_div
      $error("csc_top instruction divider must be 2 to 4");
    end
    if (CSC_SYNC_STAGES < 2) begin : g_bad_sync
      $error("csc_top needs two synchroniser stages");
    end
  endgenerate

  // ---------------- configuration state
  logic            sense_en_reg;
  logic            ref_range_reg;
  logic [1:0]      cur_reg;
  logic            ta_ext_reg;
  logic [1:0]      chan_reg;
  logic            ta_src_reg;
  logic            ta_ovf_reg;
  logic            ta_ovf_next;
  logic            tb_on_reg;
  logic            tb_gate_en_reg;
  logic            tb_gate_tog_reg;
  logic [1:0]      tb_clk_reg;
  logic [TA_W-1:0] ta_cnt_reg;
  logic [TA_W-1:0] ta_cnt_next;
  logic [TB_W-1:0] tb_cnt_reg;
  logic [TB_W-1:0] tb_cnt_next;
  logic            gate_flip_reg;
  logic [1:0]      div_reg;
  logic            ack_reg;
  logic [CSC_DATA_W-1:0] rdata_reg;
  csc_analog_t     analog_reg;
  csc_analog_t     analog_next;

  // ---------------- bus decode
  // only the listed offsets decode; anything else reads 0 and drops writes
  wire access_w   = avs_read | avs_write;
  wire wr_fire_w  = avs_write & ack_reg;
  wire sel_ctrl0  = (avs_address == CSC_OFS_CTRL0);
  wire sel_ctrl1  = (avs_address == CSC_OFS_CTRL1);
  wire sel_ta_cfg = (avs_address == CSC_OFS_TA_CFG);
  wire sel_ta_cnt = (avs_address == CSC_OFS_TA_CNT);
  wire sel_tb_cfg = (avs_address == CSC_OFS_TB_CFG);
  wire sel_tb_cnt = (avs_address == CSC_OFS_TB_CNT);
  wire wr_b0_w    = wr_fire_w & avs_byteenable[0];
  wire wr_b1_w    = wr_fire_w & avs_byteenable[1];
  wire wr_ctrl0   = wr_b0_w & sel_ctrl0;
  wire wr_ctrl1   = wr_b0_w & sel_ctrl1;
  wire wr_ta_cfg  = wr_b0_w & sel_ta_cfg;
  wire wr_ta_cnt  = wr_b0_w & sel_ta_cnt;
  wire wr_tb_cfg  = wr_b0_w & sel_tb_cfg;
  wire wr_tb_lo   = wr_b0_w & sel_tb_cnt;
  wire wr_tb_hi   = wr_b1_w & sel_tb_cnt;

  // one wait cycle per access; write lands where waitrequest is low
  assign avs_waitrequest = access_w & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  // ---------------- synchronised inputs
  logic osc_level;
  logic osc_rise;
  logic ext_rise;
  logic gate_level;

  // comparator output is async to core_clk; counts come from its sync edge
  csc_sync_edge #(.STAGES(CSC_SYNC_STAGES)) u_sync_osc (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in (osc_comp_in),
    .level    (osc_level),
    .rise     (osc_rise)
  );

  csc_sync_edge #(.STAGES(CSC_SYNC_STAGES)) u_sync_ext (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in (ext_clk_pin_in),
    .level    (),
    .rise     (ext_rise)
  );

  csc_sync_edge #(.STAGES(CSC_SYNC_STAGES)) u_sync_gate (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in (gate_pin_in),
    .level    (gate_level),
    .rise     ()
  );

  // ---------------- analog mode decode
  wire cur_zero_w   = (cur_reg == CSC_CUR_OFF_NOISE);
  wire noise_mode_w = ref_range_reg & cur_zero_w;
  wire osc_run_w    = sense_en_reg & ~(~ref_range_reg & cur_zero_w);
  wire [NUM_CH-1:0] pin_sel_w;

  // one compare per sense pin: the codes are distinct, so at most one is set
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_pin
    assign pin_sel_w[ch] = sense_en_reg & (chan_reg == 2'(ch));
  end

  always_comb begin
    analog_next               = '0;
    analog_next.pin_connect   = pin_sel_w;
    analog_next.ref_variable  = ref_range_reg;
    analog_next.osc_on        = osc_run_w;
    analog_next.current_on    = osc_run_w & ~noise_mode_w;
    analog_next.current_level = cur_reg;
  end

  assign analog_ctl = analog_reg;

  // edges only count while the oscillator is meant to run; noise mode keeps
  // counting comparator toggles, so activity on a quiet pad shows as counts
  wire osc_tick_w   = osc_rise & analog_reg.osc_on;
  wire instr_tick_w = (div_reg == 2'(CSC_INSTR_DIV - 1));

  // ---------------- timer_a
  wire ta_tick_w = ta_src_reg ? (ta_ext_reg ? osc_tick_w : ext_rise)
                              : instr_tick_w;
  wire ta_ovf_set_w = ta_tick_w & (&ta_cnt_reg);
  wire ta_ovf_clr_w = wr_ta_cfg & avs_writedata[CSC_TA_OVF_BIT];

  // load from software wins over a tick, so a clear starts a clean window
  assign ta_cnt_next = wr_ta_cnt ? avs_writedata[TA_W-1:0]
                     : (ta_tick_w ? TA_W'(ta_cnt_reg + 1'b1) : ta_cnt_reg);
  // an overflow in the clearing cycle stays flagged
  assign ta_ovf_next = ta_ovf_set_w | (ta_ovf_reg & ~ta_ovf_clr_w);

  // ---------------- timer_b
  wire tb_src_w = (tb_clk_reg == CSC_TB_CLK_OSC)   ? osc_tick_w
                : (tb_clk_reg == CSC_TB_CLK_INSTR) ? instr_tick_w
                : (tb_clk_reg == CSC_TB_CLK_CORE)  ? 1'b1
                : ext_rise;
  // toggle gate flips on each timer_a overflow: one overflow period per window
  wire gate_open_w = tb_gate_tog_reg ? gate_flip_reg : gate_level;
  wire tb_tick_w   = tb_on_reg & (~tb_gate_en_reg | gate_open_w)
                   & tb_src_w;
  wire [TB_W-1:0] tb_inc_w = tb_tick_w ? TB_W'(tb_cnt_reg + 1'b1) : tb_cnt_reg;

  // byte lanes let software load the wide count over a narrow path
  always_comb begin
    tb_cnt_next = tb_inc_w;
    if (wr_tb_lo) begin
      tb_cnt_next[7:0] = avs_writedata[7:0];
    end
    if (wr_tb_hi) begin
      tb_cnt_next[TB_W-1:8] = avs_writedata[TB_W-1:8];
    end
  end

  // ---------------- read mux
  // read words are placed by the shared field positions, so the bus view
  // cannot drift from the write decode; unused bits read 0
  logic [CSC_DATA_W-1:0] rd_ctrl0_w;
  logic [CSC_DATA_W-1:0] rd_ctrl1_w;
  logic [CSC_DATA_W-1:0] rd_ta_cfg_w;
  logic [CSC_DATA_W-1:0] rd_tb_cfg_w;

  always_comb begin
    rd_ctrl0_w                    = '0;
    rd_ctrl0_w[CSC_SENSE_EN_BIT]  = sense_en_reg;
    rd_ctrl0_w[CSC_REF_RANGE_BIT] = ref_range_reg;
    rd_ctrl0_w[CSC_CUR_LSB +: 2]  = cur_reg;
    rd_ctrl0_w[CSC_DIR_BIT]       = osc_level;
    rd_ctrl0_w[CSC_TA_EXT_BIT]    = ta_ext_reg;
  end

  always_comb begin
    rd_ctrl1_w                    = '0;
    rd_ctrl1_w[CSC_CHAN_LSB +: 2] = chan_reg;
  end

  always_comb begin
    rd_ta_cfg_w                 = '0;
    rd_ta_cfg_w[CSC_TA_SRC_BIT] = ta_src_reg;
    rd_ta_cfg_w[CSC_TA_OVF_BIT] = ta_ovf_reg;
  end

  // gate level reads back live, so software can see where a toggle window is
  always_comb begin
    rd_tb_cfg_w                      = '0;
    rd_tb_cfg_w[CSC_TB_ON_BIT]       = tb_on_reg;
    rd_tb_cfg_w[CSC_TB_GATE_EN_BIT]  = tb_gate_en_reg;
    rd_tb_cfg_w[CSC_TB_GATE_TOG_BIT] = tb_gate_tog_reg;
    rd_tb_cfg_w[CSC_TB_CLK_LSB +: 2] = tb_clk_reg;
    rd_tb_cfg_w[CSC_TB_GATE_LVL_BIT] = gate_open_w;
  end
  wire [CSC_DATA_W-1:0] rd_mux_w =
      sel_ctrl0  ? rd_ctrl0_w
    : sel_ctrl1  ? rd_ctrl1_w
    : sel_ta_cfg ? rd_ta_cfg_w
    : sel_ta_cnt ? CSC_DATA_W'(ta_cnt_reg)
    : sel_tb_cfg ? rd_tb_cfg_w
    : sel_tb_cnt ? CSC_DATA_W'(tb_cnt_reg)
    : '0;

  // ---------------- bus handshake
  // read data are captured in the wait cycle and stand in the answer cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg <= access_w & ~ack_reg;
      if (avs_read & ~ack_reg) begin
        rdata_reg <= rd_mux_w;
      end
    end
  end

  // ---------------- control registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sense_en_reg  <= 1'b0;
      ref_range_reg <= 1'b0;
      cur_reg       <= CSC_RST_CUR;
      ta_ext_reg    <= 1'b0;
      chan_reg      <= CSC_RST_CHAN;
      ta_src_reg    <= 1'b0;
    end else begin
      if (wr_ctrl0) begin
        sense_en_reg  <= avs_writedata[CSC_SENSE_EN_BIT];
        ref_range_reg <= avs_writedata[CSC_REF_RANGE_BIT];
        cur_reg       <= avs_writedata[CSC_CUR_LSB +: 2];
        ta_ext_reg    <= avs_writedata[CSC_TA_EXT_BIT];
      end
      if (wr_ctrl1) begin
        chan_reg <= avs_writedata[CSC_CHAN_LSB +: 2];
      end
      if (wr_ta_cfg) begin
        ta_src_reg <= avs_writedata[CSC_TA_SRC_BIT];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tb_on_reg       <= 1'b0;
      tb_gate_en_reg  <= 1'b0;
      tb_gate_tog_reg <= 1'b0;
      tb_clk_reg      <= CSC_RST_TB_CLK;
    end else if (wr_tb_cfg) begin
      tb_on_reg       <= avs_writedata[CSC_TB_ON_BIT];
      tb_gate_en_reg  <= avs_writedata[CSC_TB_GATE_EN_BIT];
      tb_gate_tog_reg <= avs_writedata[CSC_TB_GATE_TOG_BIT];
      tb_clk_reg      <= avs_writedata[CSC_TB_CLK_LSB +: 2];
    end
  end

  // ---------------- counters and mode outputs
  // mode outputs are registered so the pad never sees decode glitches;
  // the instruction divider free-runs from reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg       <= 2'h0;
      ta_cnt_reg    <= '0;
      ta_ovf_reg    <= 1'b0;
      tb_cnt_reg    <= '0;
      gate_flip_reg <= 1'b0;
      analog_reg    <= '0;
    end else begin
      div_reg       <= instr_tick_w ? 2'h0 : 2'(div_reg + 1'b1);
      ta_cnt_reg    <= ta_cnt_next;
      ta_ovf_reg    <= ta_ovf_next;
      tb_cnt_reg    <= tb_cnt_next;
      gate_flip_reg <= gate_flip_reg ^ ta_ovf_set_w;
      analog_reg    <= analog_next;
    end
  end

endmodule // csc_top
`default_nettype wire

// [logic/csc_pkg.sv]
// constants, field layout and carrier types of the capacitive sense control
// Summary of operation
// - Mux puts the oscillator on exactly one of four pins by channel_select; none while sense_enable is 0.
// - When enabled, channel_select places the oscillator on that pin.
// - Read-only osc_direction_status: 1 sourcing, 0 sinking current.
// - Oscillator output can clock either timer_a or timer_b.
// - reference_range_select 1: DAC and fixed_reference; 0: rail thresholds.
// - current_range_select 01 low, 10 medium, 11 high; low range 00 is off.
// - High range: current_range_select 00 selects noise detection, not off.
// - Noise detection drops pin current; rest of oscillator stays active.
// - Noise detection: comparator toggles from pin noise are counted.
// - timer_a counts oscillator when external source and ext select set.
// - timer_b counts oscillator when timer_b_clock_select equals 11.
// - timer_b off unless timer_b_on; gate_enable limits counts to gate open.
// - Counting timer increments once per oscillator cycle.
// - sense_enable 0 ignores channel_select and connects no sense pin.
// - timer_a internal source counts core clock divided by four.
package csc_pkg;

  localparam int unsigned CSC_ADDR_W = 5;
  localparam int unsigned CSC_DATA_W = 32;
  localparam int unsigned CSC_NUM_CH = 4;
  localparam int unsigned CSC_SYNC_STAGES = 2;
  localparam int unsigned CSC_INSTR_DIV = 4;

  // byte offsets, one aligned word each
  localparam logic [CSC_ADDR_W-1:0] CSC_OFS_CTRL0  = 5'h00;
  localparam logic [CSC_ADDR_W-1:0] CSC_OFS_CTRL1  = 5'h04;
  localparam logic [CSC_ADDR_W-1:0] CSC_OFS_TA_CFG = 5'h08;
  localparam logic [CSC_ADDR_W-1:0] CSC_OFS_TA_CNT = 5'h0C;
  localparam logic [CSC_ADDR_W-1:0] CSC_OFS_TB_CFG = 5'h10;
  localparam logic [CSC_ADDR_W-1:0] CSC_OFS_TB_CNT = 5'h14;

  // ctrl0 fields
  localparam int unsigned CSC_SENSE_EN_BIT  = 7;
  localparam int unsigned CSC_REF_RANGE_BIT = 6;
  localparam int unsigned CSC_CUR_LSB       = 2;
  localparam int unsigned CSC_DIR_BIT       = 1;
  localparam int unsigned CSC_TA_EXT_BIT    = 0;
  // ctrl1 fields
  localparam int unsigned CSC_CHAN_LSB      = 0;
  // timer_a config fields
  localparam int unsigned CSC_TA_SRC_BIT    = 0;
  localparam int unsigned CSC_TA_OVF_BIT    = 1;
  // timer_b config fields
  localparam int unsigned CSC_TB_ON_BIT     = 0;
  localparam int unsigned CSC_TB_GATE_EN_BIT = 1;
  localparam int unsigned CSC_TB_GATE_TOG_BIT = 2;
  localparam int unsigned CSC_TB_CLK_LSB    = 4;
  localparam int unsigned CSC_TB_GATE_LVL_BIT = 6;

  // reset values
  localparam logic [1:0] CSC_RST_CUR  = 2'h0;
  localparam logic [1:0] CSC_RST_CHAN = 2'h0;
  localparam logic [1:0] CSC_RST_TB_CLK = 2'h0;

  // current_range_select codes
  localparam logic [1:0] CSC_CUR_OFF_NOISE = 2'h0;

  // timer_b_clock_select codes
  localparam logic [1:0] CSC_TB_CLK_INSTR = 2'h0;
  localparam logic [1:0] CSC_TB_CLK_CORE  = 2'h1;
  localparam logic [1:0] CSC_TB_CLK_OSC   = 2'h3;

  typedef struct packed {
    logic [CSC_NUM_CH-1:0] pin_connect;
    logic                  ref_variable;
    logic                  osc_on;
    logic                  current_on;
    logic [1:0]            current_level;
  } csc_analog_t;

endpackage

// [logic/csc_sync_edge.sv]
// two-stage synchroniser with rising-edge pulse for an asynchronous input
`timescale 1ns/10ps
`default_nettype none
module csc_sync_edge #(
  parameter int unsigned STAGES = 2
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);

  logic [STAGES-1:0] sync_reg;
  logic              prev_reg;
  logic              rise_reg;

  generate
    if (STAGES < 2) begin : g_bad
      $error("csc_sync_edge needs at least two stages");
    end
  endgenerate

  // first stage is only read by the next stage
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync_reg <= '0;
      prev_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[STAGES-2:0], async_in};
      prev_reg <= sync_reg[STAGES-1];
      rise_reg <= sync_reg[STAGES-1] & ~prev_reg;
    end
  end

  assign level = sync_reg[STAGES-1];
  assign rise  = rise_reg;

endmodule // csc_sync_edge
`default_nettype wire

// [verification/csc_top_asserts.sv]
// port assertions for the capacitive sense control
`timescale 1ns/10ps
`default_nettype none
module csc_top_asserts
  import csc_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  rstn,
  input wire logic [CSC_ADDR_W-1:0] avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [CSC_DATA_W-1:0] avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic [CSC_DATA_W-1:0] avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic                  osc_comp_in,
  input wire logic                  ext_clk_pin_in,
  input wire logic                  gate_pin_in,
  input wire csc_analog_t           analog_ctl
);
  logic [7:0] c0_sh;
  logic [1:0] ch_sh;
  wire logic       wr_ok  = avs_write & ~avs_waitrequest;
  wire logic [9:0] cfg    = {c0_sh, ch_sh};
  wire logic       exp_on = c0_sh[7] & (c0_sh[6] | (c0_sh[3:2] != 2'h0));
  wire logic       exp_cu = exp_on & ~(c0_sh[6] & (c0_sh[3:2] == 2'h0));
  // shadow of the config words, full-word writes assumed
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      c0_sh <= 8'h00;
      ch_sh <= 2'h0;
    end else if (wr_ok && avs_address == CSC_OFS_CTRL0) begin
      c0_sh <= avs_writedata[7:0];
    end else if (wr_ok && avs_address == CSC_OFS_CTRL1) begin
      ch_sh <= avs_writedata[1:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // compare only once the shadow has settled, hides the register lag
  property p_onehot; $onehot0(analog_ctl.pin_connect); endproperty
  property p_pin_sel;
    $stable(cfg) && c0_sh[7] |-> analog_ctl.pin_connect == (4'h1 << ch_sh);
  endproperty
  property p_pin_off;
    $stable(cfg) && !c0_sh[7] |-> analog_ctl.pin_connect == 4'h0;
  endproperty
  property p_ref; $stable(cfg) |-> analog_ctl.ref_variable == c0_sh[6];
  endproperty
  property p_osc_on; $stable(cfg) |-> analog_ctl.osc_on == exp_on;
  endproperty
  property p_cur_on; $stable(cfg) |-> analog_ctl.current_on == exp_cu;
  endproperty
  property p_wait_one; avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_wait_first; $rose(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("several sense pins connected");
  a_pin_sel: assert property (p_pin_sel)
    else $error("selected pin not connected");
  a_pin_off: assert property (p_pin_off)
    else $error("pin connected while disabled");
  a_ref: assert property (p_ref)
    else $error("threshold source wrong");
  a_osc_on: assert property (p_osc_on)
    else $error("oscillator enable wrong");
  a_cur_on: assert property (p_cur_on)
    else $error("pin current enable wrong");
  a_wait_one: assert property (p_wait_one)
    else $error("wait state longer than one cycle");
  a_wait_first: assert property (p_wait_first)
    else $error("access answered without wait state");
  c_noise: cover property (analog_ctl.osc_on && !analog_ctl.current_on);
  c_pin3: cover property (analog_ctl.pin_connect == 4'h8);
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule // csc_top_asserts
bind csc_top csc_top_asserts u_asserts (.core_clk(core_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .osc_comp_in(osc_comp_in), .ext_clk_pin_in(ext_clk_pin_in),
  .gate_pin_in(gate_pin_in), .analog_ctl(analog_ctl));
`default_nettype wire

// [verification/csc_pad_model.sv]
// touch pad with relaxation oscillator on the selected sense pin
`timescale 1ns/10ps
`default_nettype none
module csc_pad_model
  import csc_pkg::*;
#(
  parameter int unsigned HALF = 4
) (
  input  wire logic        core_clk,
  input  wire csc_analog_t analog_ctl,
  input  wire logic        pin_analog,
  input  wire logic        noise,
  output logic             osc_comp_in,
  output int unsigned      rises
);
  int unsigned div;
  // a pin left digital stalls the oscillator
  wire logic linked = pin_analog & analog_ctl.osc_on
                      & (analog_ctl.pin_connect != 4'h0);
  // no pin current: only noise moves the comparator
  wire logic swing = linked & (analog_ctl.current_on | noise);
  initial begin
    osc_comp_in = 1'b0;
    rises = 0;
    div = 0;
  end
  always @(posedge core_clk) begin
    if (swing) begin
      div <= (div == HALF - 1) ? 0 : div + 1;
      if (div == HALF - 1) begin
        osc_comp_in <= ~osc_comp_in;
        if (!osc_comp_in) rises <= rises + 1;
      end
    end
  end
endmodule // csc_pad_model
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the capacitive sense control
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import csc_pkg::*;
  logic                  core_clk, rstn, avs_read, avs_write;
  logic                  gate_pin_in, pin_analog, noise, ext_pin, gate0;
  logic                  avs_waitrequest, osc_comp_in;
  logic [CSC_ADDR_W-1:0] avs_address;
  logic [CSC_DATA_W-1:0] avs_writedata, avs_readdata, rd;
  logic [3:0]            avs_byteenable;
  csc_analog_t           analog_ctl;
  int unsigned           rises, r0, miscompares, total_checks;
  csc_top dut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .osc_comp_in(osc_comp_in),
    .ext_clk_pin_in(ext_pin), .gate_pin_in(gate_pin_in),
    .analog_ctl(analog_ctl));
  csc_pad_model u_pad (.core_clk(core_clk), .analog_ctl(analog_ctl),
    .pin_analog(pin_analog), .noise(noise), .osc_comp_in(osc_comp_in),
    .rises(rises));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        miscompares++;
        finish_test();
      end
      @(posedge core_clk);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  // pad linked for n cycles, then the counter settles and is read
  task automatic measure(input logic [4:0] a, input int n);
    bus(1'b1, a, 32'h0);
    r0 = rises;
    pin_analog <= 1'b1;
    repeat (n) @(posedge core_clk);
    pin_analog <= 1'b0;
    repeat (8) @(posedge core_clk);
    bus(1'b0, a, 32'h0);
  endtask
  initial begin
    rstn = 1'b0;
    {avs_read, avs_write, gate_pin_in, pin_analog, noise, ext_pin} = 6'h00;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    miscompares = 0;
    total_checks = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, CSC_OFS_CTRL0, 32'h0); chk(rd, 32'h0);
    bus(1'b0, CSC_OFS_CTRL1, 32'h0); chk(rd, 32'h0);
    bus(1'b1, 5'h18, 32'hFFFFFFFF);
    bus(1'b0, 5'h18, 32'h0); chk(rd, 32'h0);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, CSC_OFS_CTRL1, 32'(c));
      bus(1'b1, CSC_OFS_CTRL0, 32'h8C);
      repeat (2) @(posedge core_clk);
      chk(32'(analog_ctl.pin_connect), 32'h1 << c);
      bus(1'b1, CSC_OFS_CTRL0, 32'h0C);
      repeat (2) @(posedge core_clk);
      chk(32'(analog_ctl.pin_connect), 32'h0);
    end
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, CSC_OFS_CTRL0, 32'h80 | 32'(m[2]) << 6 | 32'(m[1:0]) << 2);
      repeat (2) @(posedge core_clk);
      chk(32'({analog_ctl.ref_variable, analog_ctl.osc_on,
        analog_ctl.current_on}), 32'({m[2], m[2] || m[1:0] != 0,
        m[1:0] != 0}));
      if (m[1:0] != 0) chk(32'(analog_ctl.current_level), 32'(m[1:0]));
    end
    bus(1'b1, CSC_OFS_CTRL0, 32'h8C);
    bus(1'b1, CSC_OFS_TB_CFG, 32'h31);
    measure(CSC_OFS_TB_CNT, 200); chk(rd, rises - r0);
    bus(1'b0, CSC_OFS_CTRL0, 32'h0); chk(32'(rd[1]), 32'(osc_comp_in));
    bus(1'b1, CSC_OFS_TB_CFG, 32'h30);
    measure(CSC_OFS_TB_CNT, 200); chk(rd, 32'h0);
    bus(1'b1, CSC_OFS_TB_CFG, 32'h33);
    measure(CSC_OFS_TB_CNT, 200); chk(rd, 32'h0);
    gate_pin_in <= 1'b1;
    measure(CSC_OFS_TB_CNT, 212); chk(rd, rises - r0);
    bus(1'b0, CSC_OFS_CTRL0, 32'h0); chk(32'(rd[1]), 32'(osc_comp_in));
    gate_pin_in <= 1'b0;
    bus(1'b1, CSC_OFS_TB_CFG, 32'h31);
    bus(1'b1, CSC_OFS_CTRL0, 32'hC0);
    measure(CSC_OFS_TB_CNT, 200); chk(rd, 32'h0);
    noise <= 1'b1;
    measure(CSC_OFS_TB_CNT, 200); chk(rd, rises - r0);
    noise <= 1'b0;
    bus(1'b1, CSC_OFS_CTRL0, 32'h8D);
    bus(1'b1, CSC_OFS_TA_CFG, 32'h1);
    measure(CSC_OFS_TA_CNT, 200); chk(rd, rises - r0);
    // oscillator runs at half the divided rate, so a wrong source shows
    bus(1'b1, CSC_OFS_TA_CFG, 32'h0);
    pin_analog <= 1'b1;
    bus(1'b1, CSC_OFS_TA_CNT, 32'h0);
    repeat (400) @(posedge core_clk);
    bus(1'b0, CSC_OFS_TA_CNT, 32'h0);
    pin_analog <= 1'b0;
    chk(32'(rd >= 32'd99 && rd <= 32'd101), 32'h1);
    // one timer_a overflow must raise the flag and flip the toggle gate
    bus(1'b1, CSC_OFS_TB_CFG, 32'h37);
    bus(1'b0, CSC_OFS_TB_CFG, 32'h0);
    chk(32'(rd[5:0]), 32'h37);
    gate0 = rd[CSC_TB_GATE_LVL_BIT];
    bus(1'b1, CSC_OFS_TA_CFG, 32'h2);
    bus(1'b1, CSC_OFS_TA_CNT, 32'hFF);
    repeat (8) @(posedge core_clk);
    bus(1'b0, CSC_OFS_TA_CFG, 32'h0);
    chk(32'(rd[CSC_TA_OVF_BIT]), 32'h1);
    bus(1'b0, CSC_OFS_TB_CFG, 32'h0);
    chk(32'(rd[CSC_TB_GATE_LVL_BIT]), 32'(!gate0));
    // external pin clocks timer_b, then a single-lane load while off
    bus(1'b1, CSC_OFS_TB_CFG, 32'h21);
    bus(1'b1, CSC_OFS_TB_CNT, 32'h0);
    repeat (5) begin
      ext_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      ext_pin <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    bus(1'b0, CSC_OFS_TB_CNT, 32'h0);
    chk(rd, 32'h5);
    bus(1'b1, CSC_OFS_TB_CFG, 32'h0);
    avs_byteenable <= 4'h2;
    bus(1'b1, CSC_OFS_TB_CNT, 32'hA5A5);
    avs_byteenable <= 4'hF;
    bus(1'b0, CSC_OFS_TB_CNT, 32'h0);
    chk(rd, 32'hA505);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
